// ---- rtl/link_pulse_defs.svh ----
`ifndef LINK_PULSE_DEFS_SVH
`define LINK_PULSE_DEFS_SVH

// ------------------------------------------------------------
// clock and conversion of times into cycle counts
// ------------------------------------------------------------
`define CLK_PERIOD_NS        100.0
`define UNIT_NS              1.0
`define UNIT_US              1000.0
`define UNIT_MS              1000000.0
`define CYC_UP(t, u)         int'($ceil((t) * (u) / `CLK_PERIOD_NS))
`define CYC_DN(t, u)         int'($floor((t) * (u) / `CLK_PERIOD_NS))

// ------------------------------------------------------------
// link pulse timing
// ------------------------------------------------------------
`define PAGE_BITS            16
`define T_NLP_TX_MIN_MS      8.0
`define T_NLP_TX_MAX_MS      24.0
`define T_RX_PULSE_MIN_NS    50.0
`define T_LINK_TEST_MIN_MS   6.0
`define T_LINK_LOSS_MS       50.0
`define LINK_PASS_PULSES     3
`define T_FLP_TX_WIDTH_NS    100.0
`define T_FLP_DATA_NOM_US    62.5
`define T_BURST_TX_MIN_MS    8.0
`define T_BURST_TX_MAX_MS    22.0
`define T_FLP_TEST_MIN_US    5.0
`define T_FLP_TEST_MAX_US    165.0
`define T_DATA_MIN_US        15.0
`define T_DATA_MAX_US        78.0
`define FLP_BURST_PULSES     17
`define T_BURST_TEST_MIN_MS  5.0
`define T_BURST_TEST_MAX_MS  50.0
`define BURSTS_FOR_CAPABLE   3
`define T_ACK_FAIL_MS        1200.0
`define T_BREAK_LINK_MS      1200.0
`define T_LINK_INHIBIT_MS    750.0

`endif

// ---- rtl/link_pulse_pkg.sv ----
`include "link_pulse_defs.svh"

package link_pulse_pkg;

   // per-channel inputs
   typedef struct packed {
      logic                    an_enable;
      logic                    restart_an;
      logic                    ack_done;
      logic                    link_ready;
      logic                    rx_packet;
      logic                    rx_pulse;
      logic [`PAGE_BITS-1:0]   tx_page;
   } chan_in_type;

   // per-channel outputs
   typedef struct packed {
      logic                    tx_pulse;
      logic                    link_pass;
      logic                    an_capable;
      logic                    page_valid;
      logic [`PAGE_BITS-1:0]   rx_page;
      logic                    ack_fail;
      logic                    inhibit_fail;
   } chan_out_type;

   typedef enum logic [1:0] {TX_NLP, TX_BREAK, TX_GAP, TX_BURST} tx_state_type;
   typedef enum logic {RX_IDLE, RX_BURST} rx_state_type;
   typedef enum logic [2:0] {AN_OFF, AN_ACK, AN_INHIBIT, AN_LINKED, AN_FAILED} an_state_type;

endpackage

// ---- rtl/link_pulse_timing.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "link_pulse_defs.svh"

module link_pulse_timing
   import link_pulse_pkg::*;
#(
   parameter int CHANNELS       = 4,
   parameter int TW             = 24,
   parameter int NLP_TX_CYC     = `CYC_UP((`T_NLP_TX_MIN_MS + `T_NLP_TX_MAX_MS) / 2.0, `UNIT_MS),
   parameter int LINK_MIN_CYC   = `CYC_UP(`T_LINK_TEST_MIN_MS, `UNIT_MS),
   parameter int LINK_LOSS_CYC  = `CYC_UP(`T_LINK_LOSS_MS, `UNIT_MS),
   parameter int BURST_TX_CYC   = `CYC_UP((`T_BURST_TX_MIN_MS + `T_BURST_TX_MAX_MS) / 2.0, `UNIT_MS),
   parameter int BURST_MIN_CYC  = `CYC_UP(`T_BURST_TEST_MIN_MS, `UNIT_MS),
   parameter int BURST_MAX_CYC  = `CYC_UP(`T_BURST_TEST_MAX_MS, `UNIT_MS),
   parameter int ACK_FAIL_CYC   = `CYC_UP(`T_ACK_FAIL_MS, `UNIT_MS),
   parameter int BREAK_CYC      = `CYC_UP(`T_BREAK_LINK_MS, `UNIT_MS),
   parameter int INHIBIT_CYC    = `CYC_UP(`T_LINK_INHIBIT_MS, `UNIT_MS)
)(
   input  wire logic                        sys_clk,
   input  wire logic                        reset_n,
   input  wire chan_in_type [CHANNELS-1:0]  chan_in,
   output wire chan_out_type [CHANNELS-1:0] chan_out
);

   // ------------------------------------------------------------
   // derived counts
   // ------------------------------------------------------------
   localparam int RX_W_CYC   = `CYC_UP(`T_RX_PULSE_MIN_NS, `UNIT_NS);
   localparam int FLP_W_CYC  = `CYC_UP(`T_FLP_TX_WIDTH_NS, `UNIT_NS);
   localparam int DOFS_CYC   = `CYC_UP(`T_FLP_DATA_NOM_US, `UNIT_US);
   localparam int FMIN_CYC   = `CYC_UP(`T_FLP_TEST_MIN_US, `UNIT_US);
   localparam int FMAX_CYC   = `CYC_UP(`T_FLP_TEST_MAX_US, `UNIT_US);
   localparam int DMIN_CYC   = `CYC_UP(`T_DATA_MIN_US, `UNIT_US);
   localparam int DMAX_CYC   = `CYC_DN(`T_DATA_MAX_US, `UNIT_US);

   localparam logic [3:0]    RX_W    = 4'(RX_W_CYC);
   localparam logic [3:0]    FLP_W   = 4'(FLP_W_CYC);
   localparam logic [TW-1:0] NLP_P   = TW'(NLP_TX_CYC - 1);
   localparam logic [TW-1:0] LT_MIN  = TW'(LINK_MIN_CYC);
   localparam logic [TW-1:0] LOSS    = TW'(LINK_LOSS_CYC);
   localparam logic [TW-1:0] BURST_P = TW'(BURST_TX_CYC - 1);
   localparam logic [TW-1:0] BRK_P   = TW'(BREAK_CYC - 1);
   localparam logic [TW-1:0] DOFS_P  = TW'(DOFS_CYC - 1);
   localparam logic [TW-1:0] FMIN    = TW'(FMIN_CYC);
   localparam logic [TW-1:0] FMAX    = TW'(FMAX_CYC);
   localparam logic [TW-1:0] DMIN    = TW'(DMIN_CYC);
   localparam logic [TW-1:0] DMAX    = TW'(DMAX_CYC);
   localparam logic [TW-1:0] BMIN    = TW'(BURST_MIN_CYC);
   localparam logic [TW-1:0] BMAX    = TW'(BURST_MAX_CYC);
   localparam logic [TW-1:0] ACK_P   = TW'(ACK_FAIL_CYC - 1);
   localparam logic [TW-1:0] LFI_P   = TW'(INHIBIT_CYC - 1);
   localparam logic [1:0]    PASS_N  = 2'(`LINK_PASS_PULSES - 1);
   localparam logic [4:0]    CLKS_N  = 5'(`FLP_BURST_PULSES);
   localparam logic [1:0]    SEQ_N   = 2'(`BURSTS_FOR_CAPABLE);
   localparam logic [5:0]    SLOT_L  = 6'(2 * (`FLP_BURST_PULSES - 1));

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (CHANNELS < 1 || TW < 12 || TW > 31)
      $error("link_pulse_timing: bad channel count or timer width");
   if (NLP_TX_CYC >= 2**TW || LINK_LOSS_CYC >= 2**TW || BURST_TX_CYC >= 2**TW ||
       BURST_MAX_CYC >= 2**TW || ACK_FAIL_CYC >= 2**TW || BREAK_CYC >= 2**TW ||
       INHIBIT_CYC >= 2**TW || NLP_TX_CYC < 2 || BURST_TX_CYC < 2)
      $error("link_pulse_timing: timer count does not fit the timer width");
   if (RX_W_CYC > 15 || FLP_W_CYC > 15 || FLP_W_CYC < 1)
      $error("link_pulse_timing: pulse width count out of range");

   // saturating timer step, shared by every TW-bit timer
   function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
      return (&v) ? v : v + 1'b1;
   endfunction

   // ------------------------------------------------------------
   // one independent timer set per channel
   // ------------------------------------------------------------
   for (genvar g = 0; g < CHANNELS; g++) begin : chan
      chan_in_type                ci;
      logic                       evt;
      logic                       clr;
      logic                       fire;
      logic                       rx_q,    rx_d;
      logic [3:0]                 wid_q,   wid_d;
      logic [TW-1:0]              nlp_t_q, nlp_t_d;
      logic                       fail_q,  fail_d;
      logic [1:0]                 pass_q,  pass_d;
      tx_state_type               tx_st_q, tx_st_d;
      logic [TW-1:0]              tx_t_q,  tx_t_d;
      logic [TW-1:0]              sl_t_q,  sl_t_d;
      logic [5:0]                 slot_q,  slot_d;
      logic [3:0]                 pw_q,    pw_d;
      logic                       pulse_q, pulse_d;
      rx_state_type               rs_q,    rs_d;
      logic [TW-1:0]              cp_t_q,  cp_t_d;
      logic [4:0]                 cnt_q,   cnt_d;
      logic                       ds_q,    ds_d;
      logic [`PAGE_BITS-1:0]      sr_q,    sr_d;
      logic [TW-1:0]              bt_t_q,  bt_t_d;
      logic [TW-1:0]              gap_q,   gap_d;
      logic [1:0]                 seq_q,   seq_d;
      logic                       cap_q,   cap_d;
      logic [`PAGE_BITS-1:0]      page_q,  page_d;
      logic                       pv_q,    pv_d;
      an_state_type               an_q,    an_d;
      logic [TW-1:0]              at_q,    at_d;
      logic                       af_q,    af_d;
      logic                       if_q,    if_d;

      assign ci  = chan_in[g];
      // falling edge of a wide enough pulse is one qualified event
      assign evt = rx_q & ~ci.rx_pulse & (wid_q >= RX_W);
      assign clr = ci.restart_an | ~ci.an_enable;

      // next-state logic for the whole channel
      always_comb begin
         rx_d    = ci.rx_pulse;
         wid_d   = ci.rx_pulse ? ((&wid_q) ? wid_q : wid_q + 4'h1) : 4'h0;
         // receive link integrity
         nlp_t_d = sat_inc(nlp_t_q);
         fail_d  = fail_q;
         pass_d  = pass_q;
         if (ci.rx_packet)
            nlp_t_d = '0;
         if (evt) begin
            if (nlp_t_q < LT_MIN) begin
               pass_d = 2'h0;
            end else begin
               nlp_t_d = '0;
               if (fail_q) begin
                  if (pass_q == PASS_N) begin
                     fail_d = 1'b0;
                     pass_d = 2'h0;
                  end else begin
                     pass_d = pass_q + 2'h1;
                  end
               end
            end
         end else if (nlp_t_q >= LOSS) begin
            fail_d = 1'b1;
            pass_d = 2'h0;
         end
         // transmit pulse scheduling
         tx_st_d = tx_st_q;
         tx_t_d  = sat_inc(tx_t_q);
         sl_t_d  = sat_inc(sl_t_q);
         slot_d  = slot_q;
         fire    = 1'b0;
         case (tx_st_q)
            TX_NLP: begin
               if (ci.an_enable) begin
                  tx_st_d = TX_GAP;
                  tx_t_d  = '0;
               end else if (tx_t_q >= NLP_P) begin
                  fire   = 1'b1;
                  tx_t_d = '0;
               end
            end
            TX_BREAK: begin
               // silent; first burst follows at once
               if (tx_t_q >= BRK_P) begin
                  tx_st_d = TX_GAP;
                  tx_t_d  = BURST_P;
               end
            end
            TX_GAP: begin
               if (tx_t_q >= BURST_P) begin
                  tx_st_d = TX_BURST;
                  tx_t_d  = '0;
                  slot_d  = 6'h0;
                  sl_t_d  = '0;
               end
            end
            TX_BURST: begin
               // even slots carry clocks, odd slots the page bits
               if (sl_t_q == '0) begin
                  fire = ~slot_q[0] | ci.tx_page[slot_q[4:1]];
                  if (slot_q == SLOT_L)
                     tx_st_d = TX_GAP;
               end
               if (sl_t_q >= DOFS_P) begin
                  sl_t_d = '0;
                  slot_d = slot_q + 6'h1;
               end
            end
            default: tx_st_d = TX_NLP;
         endcase
         if (!ci.an_enable && tx_st_q != TX_NLP) begin
            tx_st_d = TX_NLP;
            tx_t_d  = '0;
         end
         if (ci.restart_an && ci.an_enable) begin
            tx_st_d = TX_BREAK;
            tx_t_d  = '0;
            fire    = 1'b0;
         end
         pw_d    = fire ? FLP_W : ((pw_q != 4'h0) ? pw_q - 4'h1 : 4'h0);
         pulse_d = (pw_d != 4'h0);
         // received burst decoding
         rs_d   = rs_q;
         cp_t_d = sat_inc(cp_t_q);
         cnt_d  = cnt_q;
         ds_d   = ds_q;
         sr_d   = sr_q;
         bt_t_d = sat_inc(bt_t_q);
         gap_d  = gap_q;
         seq_d  = seq_q;
         cap_d  = cap_q;
         page_d = page_q;
         pv_d   = 1'b0;
         case (rs_q)
            RX_IDLE: begin
               if (evt && ci.an_enable) begin
                  rs_d   = RX_BURST;
                  cp_t_d = '0;
                  cnt_d  = 5'h1;
                  ds_d   = 1'b0;
                  gap_d  = bt_t_q;
                  bt_t_d = '0;
               end
            end
            RX_BURST: begin
               if (evt) begin
                  if (cp_t_q < FMIN) begin
                     ds_d = ds_q;
                  end else if (cp_t_q >= DMIN && cp_t_q < DMAX) begin
                     ds_d = 1'b1;
                  end else if (cp_t_q >= DMAX) begin
                     cp_t_d = '0;
                     cnt_d  = (&cnt_q) ? cnt_q : cnt_q + 5'h1;
                     sr_d   = {ds_q, sr_q[`PAGE_BITS-1:1]};
                     ds_d   = 1'b0;
                  end
               end else if (cp_t_q >= FMAX) begin
                  rs_d = RX_IDLE;
                  if (cnt_q == CLKS_N && gap_q >= BMIN) begin
                     if (gap_q > BMAX)
                        seq_d = 2'h1;
                     else if (seq_q != SEQ_N)
                        seq_d = seq_q + 2'h1;
                     if (seq_d == SEQ_N) begin
                        cap_d  = 1'b1;
                        page_d = sr_q;
                        pv_d   = 1'b1;
                     end
                  end
               end
            end
            default: rs_d = RX_IDLE;
         endcase
         if (clr) begin
            rs_d  = RX_IDLE;
            seq_d = 2'h0;
            cap_d = 1'b0;
         end
         // negotiation supervision; a fail raised in a clear cycle survives
         an_d = an_q;
         at_d = sat_inc(at_q);
         af_d = af_q & ~clr;
         if_d = if_q & ~clr;
         case (an_q)
            AN_OFF: begin
               if (cap_q) begin
                  an_d = AN_ACK;
                  at_d = '0;
               end
            end
            AN_ACK: begin
               if (ci.ack_done) begin
                  an_d = AN_INHIBIT;
                  at_d = '0;
               end else if (at_q >= ACK_P) begin
                  af_d = 1'b1;
                  an_d = AN_FAILED;
               end
            end
            AN_INHIBIT: begin
               if (ci.link_ready) begin
                  an_d = AN_LINKED;
               end else if (at_q >= LFI_P) begin
                  if_d = 1'b1;
                  an_d = AN_FAILED;
               end
            end
            AN_LINKED: begin
               if (!ci.link_ready)
                  an_d = AN_OFF;
            end
            AN_FAILED: an_d = AN_FAILED;
            default:   an_d = AN_OFF;
         endcase
         if (clr)
            an_d = AN_OFF;
      end

      // channel registers; link starts failed, burst gap starts long
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            rx_q    <= 1'b0;
            wid_q   <= 4'h0;
            nlp_t_q <= '0;
            fail_q  <= 1'b1;
            pass_q  <= 2'h0;
            tx_st_q <= TX_NLP;
            tx_t_q  <= '0;
            sl_t_q  <= '0;
            slot_q  <= 6'h0;
            pw_q    <= 4'h0;
            pulse_q <= 1'b0;
            rs_q    <= RX_IDLE;
            cp_t_q  <= '0;
            cnt_q   <= 5'h0;
            ds_q    <= 1'b0;
            sr_q    <= '0;
            bt_t_q  <= '1;
            gap_q   <= '1;
            seq_q   <= 2'h0;
            cap_q   <= 1'b0;
            page_q  <= '0;
            pv_q    <= 1'b0;
            an_q    <= AN_OFF;
            at_q    <= '0;
            af_q    <= 1'b0;
            if_q    <= 1'b0;
         end else begin
            rx_q    <= rx_d;
            wid_q   <= wid_d;
            nlp_t_q <= nlp_t_d;
            fail_q  <= fail_d;
            pass_q  <= pass_d;
            tx_st_q <= tx_st_d;
            tx_t_q  <= tx_t_d;
            sl_t_q  <= sl_t_d;
            slot_q  <= slot_d;
            pw_q    <= pw_d;
            pulse_q <= pulse_d;
            rs_q    <= rs_d;
            cp_t_q  <= cp_t_d;
            cnt_q   <= cnt_d;
            ds_q    <= ds_d;
            sr_q    <= sr_d;
            bt_t_q  <= bt_t_d;
            gap_q   <= gap_d;
            seq_q   <= seq_d;
            cap_q   <= cap_d;
            page_q  <= page_d;
            pv_q    <= pv_d;
            an_q    <= an_d;
            at_q    <= at_d;
            af_q    <= af_d;
            if_q    <= if_d;
         end
      end

      // outputs straight from flops
      assign chan_out[g].tx_pulse     = pulse_q;
      assign chan_out[g].link_pass    = ~fail_q;
      assign chan_out[g].an_capable   = cap_q;
      assign chan_out[g].page_valid   = pv_q;
      assign chan_out[g].rx_page      = page_q;
      assign chan_out[g].ack_fail     = af_q;
      assign chan_out[g].inhibit_fail = if_q;
   end

endmodule

`default_nettype wire

// ---- verif/link_pulse_timing_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// per-channel timing checker
// ------------------------------------------------------------
module link_pulse_timing_sva
   import link_pulse_pkg::*;
#(
   parameter int CHANNELS      = 4,
   parameter int NLP_TX_CYC    = 200,
   parameter int LINK_LOSS_CYC = 500
)(
   input wire logic                        sys_clk,
   input wire logic                        reset_n,
   input wire chan_in_type [CHANNELS-1:0]  chan_in,
   input wire chan_out_type [CHANNELS-1:0] chan_out
);
   localparam int ACK_HI = 305;
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      logic [31:0]  gap_q, gap_d, quiet_q, quiet_d, brk_q, brk_d;
      logic [2:0]   evn_q, evn_d;
      logic         sw_q, sw_d, rx_q;
      chan_in_type  i;
      chan_out_type o;
      assign i = chan_in[c];
      assign o = chan_out[c];
      // helper counts; short runs keep 32 bits far from wrapping
      always_comb begin
         gap_d   = o.tx_pulse ? 32'h1 : gap_q + 32'h1;
         sw_d    = i.an_enable | i.restart_an | (sw_q & ~o.tx_pulse);
         quiet_d = (i.rx_pulse | i.rx_packet) ? 32'h0 : quiet_q + 32'h1;
         brk_d   = !i.an_enable ? 32'hffff : (i.restart_an ? 32'h0 : brk_q + 32'h1);
         evn_d   = o.link_pass ? 3'h0 : evn_q + {2'h0, rx_q & ~i.rx_pulse & (evn_q != 3'h7)};
      end
      // sw_q marks a mode change, after which the nlp phase is free
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            {gap_q, sw_q, quiet_q} <= {32'h0, 1'b1, 32'h0};
            {brk_q, evn_q, rx_q}   <= {32'hffff, 3'h0, 1'b0};
         end else begin
            {gap_q, sw_q, quiet_q} <= {gap_d, sw_d, quiet_d};
            {brk_q, evn_q, rx_q}   <= {brk_d, evn_d, i.rx_pulse};
         end
      end
      a_pulse_single: assert property (@(posedge sys_clk) disable iff (!reset_n)
         o.tx_pulse |=> !o.tx_pulse) else $error("tx pulse too long");
      a_nlp_early: assert property (@(posedge sys_clk) disable iff (!reset_n)
         o.tx_pulse && !i.an_enable && !sw_q |-> gap_q == NLP_TX_CYC)
         else $error("nlp period wrong");
      a_nlp_late: assert property (@(posedge sys_clk) disable iff (!reset_n)
         !i.an_enable && !sw_q |-> gap_q <= NLP_TX_CYC) else $error("nlp missing");
      a_loss_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
         quiet_q > LINK_LOSS_CYC + 4 |-> !o.link_pass) else $error("link kept too long");
      a_pass_three: assert property (@(posedge sys_clk) disable iff (!reset_n)
         $rose(o.link_pass) |-> evn_q >= 3'h3) else $error("link up too early");
      a_page_capable: assert property (@(posedge sys_clk) disable iff (!reset_n)
         o.page_valid |-> o.an_capable) else $error("page before capable");
      a_ack_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
         $rose(o.an_capable) |-> ##[0:ACK_HI]
         (o.ack_fail || i.ack_done || i.restart_an || !i.an_enable))
         else $error("ack fail missing");
      a_ack_early: assert property (@(posedge sys_clk) disable iff (!reset_n)
         $rose(o.ack_fail) |-> $past(o.an_capable, 295)) else $error("ack fail early");
      a_inhibit_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
         i.ack_done && o.an_capable && !o.ack_fail |-> ##[0:ACK_HI]
         (o.inhibit_fail || i.link_ready || i.restart_an || !i.an_enable))
         else $error("inhibit fail missing");
      a_break_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
         brk_q >= 32'h1 && brk_q < 32'h122 |-> !o.tx_pulse) else $error("pulse in break");
   end
endmodule
`default_nettype wire

// ---- verif/link_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// remote link partner on the cable
// ------------------------------------------------------------
module link_partner (
   input  wire logic sys_clk,
   output var logic  rx_line
);
   // line rests low between pulses
   initial rx_line = 1'b0;
   // one pulse, one cycle high
   task automatic pulse();
      @(posedge sys_clk) rx_line <= 1'b1;
      @(posedge sys_clk) rx_line <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // clocks 1250 apart, data 625 after its clock, bit0 first; a glitch
   // adds a stray pulse 100 after each clock that must be ignored
   task automatic burst(input logic [15:0] page, input int nclk, input bit glitch);
      for (int k = 0; k < nclk; k++) begin
         pulse();
         if (glitch) begin
            idle(98);
            pulse();
            idle(523);
         end else begin
            idle(623);
         end
         if (k < nclk - 1) begin
            if (page[k]) pulse();
            else idle(2);
            idle(623);
         end
      end
   endtask
endmodule
`default_nettype wire

// ---- verif/link_pulse_timing_test.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// link pulse timing bench
// ------------------------------------------------------------
module link_pulse_timing_test
   import link_pulse_pkg::*;
;
   logic               sys_clk;
   logic               reset_n;
   logic               rx_line;
   chan_in_type [3:0]  cin;
   chan_in_type [3:0]  chan_in;
   chan_out_type [3:0] chan_out;
   int                 errors;
   int                 n_tests;
   int                 cyc;

   // the partner's line reaches every channel; channels 2 and 3 follow
   // channels 0 and 1 so no input sits tied, and channel 3 runs the
   // opposite mode to channel 1 to show channel independence
   always_comb begin
      chan_in = cin;
      for (int c = 0; c < 4; c++) begin
         chan_in[c]            = cin[c % 2];
         chan_in[c].restart_an = cin[0].restart_an;
         chan_in[c].rx_packet  = cin[0].rx_packet;
         chan_in[c].link_ready = cin[0].link_ready;
         chan_in[c].tx_page    = cin[1].tx_page;
         chan_in[c].rx_pulse   = rx_line;
      end
      chan_in[3].an_enable = ~cin[1].an_enable;
   end

   link_pulse_timing #(.NLP_TX_CYC(200), .LINK_MIN_CYC(60), .LINK_LOSS_CYC(500),
      .BURST_TX_CYC(25000), .BURST_MIN_CYC(5000), .BURST_MAX_CYC(50000),
      .ACK_FAIL_CYC(300), .BREAK_CYC(300), .INHIBIT_CYC(300)) link_pulse_timing_inst (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .chan_in  (chan_in),
      .chan_out (chan_out)
   );
   link_partner link_partner_inst (.sys_clk(sys_clk), .rx_line(rx_line));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // compares and waits
   // ------------------------------------------------------------
   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t bit %b exp %b", $time, got, exp);
      end
   endtask
   task automatic check_page(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t page %h exp %h", $time, got, exp);
      end
   endtask
   // cycle spacings allow a few cycles of pipeline slack
   task automatic check_near(input int got, input int exp);
      n_tests++;
      if (got < exp - 3 || got > exp + 3) begin
         errors++;
         $display("MISMATCH %0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // wait for tx_pulse or page_valid of a channel; t is cycles waited
   task automatic wait_for(input int c, input int lim, input bit pg, output int t);
      for (t = 1; t <= lim; t++) begin
         tick(1);
         if ((pg ? chan_out[c].page_valid : chan_out[c].tx_pulse) === 1'b1) return;
      end
      errors++;
      stop_test();
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_nlp();
      int t;
      wait_for(0, 300, 0, t);
      wait_for(0, 300, 0, t);
      check_near(t, 200);
   endtask
   task automatic t_link();
      link_partner_inst.pulse();
      link_partner_inst.idle(100);
      link_partner_inst.pulse();
      link_partner_inst.idle(30);
      link_partner_inst.pulse(); // too soon: count starts over
      for (int k = 0; k < 3; k++) begin
         tick(3);
         check_bit(chan_out[0].link_pass, k == 3);
         link_partner_inst.idle(100);
         link_partner_inst.pulse();
      end
      tick(3);
      check_bit(chan_out[0].link_pass, 1'b1);
      for (int k = 0; k < 4; k++) begin
         tick(300);
         @(posedge sys_clk) cin[0].rx_packet <= 1'b1;
         @(posedge sys_clk) cin[0].rx_packet <= 1'b0;
      end
      tick(450);
      check_bit(chan_out[0].link_pass, 1'b1);
      tick(70);
      check_bit(chan_out[0].link_pass, 1'b0);
   endtask
   task automatic t_flp();
      int t;
      int t0;
      @(posedge sys_clk);
      cin[0].an_enable <= 1'b1;
      cin[1].an_enable <= 1'b1;
      cin[1].tx_page   <= 16'h0001;
      fork
         begin
            wait_for(1, 26000, 0, t);
            t0 = cyc;
            check_near(t, 25001);
            wait_for(1, 700, 0, t);
            check_near(t, 625);
            wait_for(1, 700, 0, t);
            check_near(t, 625);
            wait_for(1, 1400, 0, t);
            check_near(t, 1250);
            tick(20000);
            wait_for(1, 4000, 0, t);
            check_near(cyc - t0, 25000);
         end
         begin
            link_partner_inst.burst(16'ha5c3, 17, 0);
            link_partner_inst.idle(1700);
            link_partner_inst.burst(16'ha5c3, 16, 0);
            link_partner_inst.idle(1700);
            link_partner_inst.burst(16'ha5c3, 17, 1);
            link_partner_inst.idle(1700);
            check_bit(chan_out[0].an_capable, 1'b0);
            link_partner_inst.burst(16'ha5c3, 17, 0);
            wait_for(0, 2000, 1, t);
            check_page(chan_out[0].rx_page, 16'ha5c3);
            check_bit(chan_out[0].an_capable, 1'b1);
            check_bit(chan_out[3].an_capable, 1'b0);
         end
      join
   endtask
   // ch0 acknowledges but never links; ch1 never acknowledges
   task automatic t_neg();
      tick(48);
      @(posedge sys_clk) cin[0].ack_done <= 1'b1;
      @(posedge sys_clk) cin[0].ack_done <= 1'b0;
      tick(238);
      check_bit(chan_out[1].ack_fail, 1'b0);
      tick(20);
      check_bit(chan_out[1].ack_fail, 1'b1);
      check_bit(chan_out[0].ack_fail, 1'b0);
      tick(30);
      check_bit(chan_out[0].inhibit_fail, 1'b0);
      tick(20);
      check_bit(chan_out[0].inhibit_fail, 1'b1);
      @(posedge sys_clk) cin[0].link_ready <= 1'b1;
      tick(2);
      check_bit(chan_out[0].inhibit_fail, 1'b1);
   endtask
   task automatic t_break();
      int t;
      @(posedge sys_clk) cin[0].restart_an <= 1'b1;
      @(posedge sys_clk) cin[0].restart_an <= 1'b0;
      tick(2);
      check_bit(chan_out[0].inhibit_fail | chan_out[0].an_capable, 1'b0);
      wait_for(0, 400, 0, t);
      check_near(t, 299);
   endtask

   // watchdog ends a hung run
   initial begin
      repeat (120000) @(posedge sys_clk);
      errors++;
      stop_test();
   end
   initial begin
      errors  = 0;
      n_tests = 0;
      cyc     = 0;
      reset_n = 1'b0;
      cin     = '0;
      tick(5);
      for (int c = 0; c < 4; c++) begin
         check_bit(|chan_out[c], 1'b0);
      end
      @(posedge sys_clk) reset_n <= 1'b1;
      t_nlp();
      t_link();
      t_flp();
      t_neg();
      t_break();
      stop_test();
   end
endmodule

bind link_pulse_timing link_pulse_timing_sva #(
   .CHANNELS(CHANNELS), .NLP_TX_CYC(NLP_TX_CYC), .LINK_LOSS_CYC(LINK_LOSS_CYC)
) link_pulse_timing_sva_inst (
   .sys_clk  (sys_clk),
   .reset_n  (reset_n),
   .chan_in  (chan_in),
   .chan_out (chan_out)
);
`default_nettype wire
